// File: core/tks_defines.svh
// Notes on behaviour
// - on command, talk request goes low at once; channel-one select after 60 ms.
// - while talk request is active and the limiter has not fired, keyed supply, exciter supply and antenna/mute assert.
// - talk request starts the transmit time limiter.
// - in repeater setups an active talk request blocks the squelch-gate keying path.
// - talk request clears the tone-squelch bypass latch only with tone and dc control.
// - exciter supply alone does not key; channel-one select must also be asserted.
// - keyed supply gate selects the normal tone encoder phase while asserted.
// - antenna/mute energizes the antenna relay and disables receive audio drivers.
// - on command removal talk request rises at once; supply and select hang 180 ms.
// - keyed supply removal triggers reverse tone burst or digital turn-off code.
// - stations without coded squelch also stay keyed through the same hang time.
// - exciter supply stays on as long as the delayed keyed supply is present.
// - hang end drops delayed supply, channel-one select and exciter supply together.
// - after exciter supply drops, wait 30 ms, then release antenna/mute high.
// - keying past the limiter period forces exciter off; antenna delay then follows.
// - limiter period is chosen from several settings by static straps.
`ifndef TKS_DEFINES_SVH
`define TKS_DEFINES_SVH

`define TKS_CLK_PERIOD_NS 100
`define TKS_TICK_NS 1000000
`define TKS_CH1_DELAY_MS 60
`define TKS_HANG_MS 180
`define TKS_ANT_DELAY_MS 30
`define TKS_TOT_SEL0_MS 30000
`define TKS_TOT_SEL1_MS 60000
`define TKS_TOT_SEL2_MS 90000
`define TKS_TOT_SEL3_MS 120000
`define TKS_MS_W 8
`define TKS_TOT_W 18
`define TKS_TICK_W 16

`endif

// File: core/tks_pkg.sv
`default_nettype none
package tks_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_KEYUP = 3'h1,
        ST_KEYED = 3'h2,
        ST_HANG = 3'h3,
        ST_ANT = 3'h4
    } tks_state_t;
endpackage : tks_pkg
`default_nettype wire

// File: core/tks_tick_if.sv
`default_nettype none
interface tks_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface : tks_tick_if
`default_nettype wire

// File: core/tks_tick_gen.sv
`include "tks_defines.svh"
`default_nettype none
module tks_tick_gen #(
    parameter int TICK_CYCLES = `TKS_TICK_NS / `TKS_CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst_n,
    tks_tick_if.src tk
);
    logic [`TKS_TICK_W-1:0] div_ff;
    logic tick_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_ff <= '0;
            tick_ff <= 1'b0;
        end else if (div_ff == `TKS_TICK_W'(TICK_CYCLES - 1)) begin
            div_ff <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff + `TKS_TICK_W'(1);
            tick_ff <= 1'b0;
        end
    end

    assign tk.tick = tick_ff;

    AST_TICK_SPACING: assert property (@(posedge clk) disable iff (!rst_n)
        tick_ff |=> !tick_ff)
        else $error("tick lasted more than one cycle");
endmodule : tks_tick_gen
`default_nettype wire

// File: core/tks_sequencer.sv
`include "tks_defines.svh"
`default_nettype none
module tks_sequencer #(
    parameter int TICK_CYCLES = `TKS_TICK_NS / `TKS_CLK_PERIOD_NS,
    parameter int TOT0_MS = `TKS_TOT_SEL0_MS,
    parameter int TOT1_MS = `TKS_TOT_SEL1_MS,
    parameter int TOT2_MS = `TKS_TOT_SEL2_MS,
    parameter int TOT3_MS = `TKS_TOT_SEL3_MS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic line_cmd_pos,
    input wire logic cfg_tone_and_dc,
    input wire logic cfg_repeater,
    input wire logic [1:0] tot_sel,
    output logic line_talk_request_n,
    output logic keyed_supply_gate,
    output logic delayed_keyed_supply,
    output logic exciter_supply_en,
    output logic channel_one_select,
    output logic tx_keyed,
    output logic ant_switch_mute_n,
    output logic ant_relay_en,
    output logic rx_audio_drv_en,
    output logic tone_phase_normal,
    output logic encoder_turnoff,
    output logic squelch_gate_block,
    output logic tone_squelch_bypass_clr,
    output logic key_inhibit
);
    // ==========================================================
    // input synchronisers
    // ==========================================================
    logic cmd_meta_ff, cmd_ff;
    logic [3:0] cfg_meta_ff, cfg_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_meta_ff <= 1'b0;
            cmd_ff <= 1'b0;
        end else begin
            cmd_meta_ff <= line_cmd_pos;
            cmd_ff <= cmd_meta_ff;
        end
    end

    // straps are static but still cross from pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_meta_ff <= 4'h0;
            cfg_ff <= 4'h0;
        end else begin
            cfg_meta_ff <= {tot_sel, cfg_repeater, cfg_tone_and_dc};
            cfg_ff <= cfg_meta_ff;
        end
    end

    // ==========================================================
    // millisecond tick
    // ==========================================================
    tks_tick_if tk_if ();
    tks_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .tk(tk_if.src)
    );
    logic tick;
    assign tick = tk_if.tick;

    // ==========================================================
    // transmit time limiter
    // ==========================================================
    logic [`TKS_TOT_W-1:0] tot_cnt_ff;
    logic [`TKS_TOT_W-1:0] tot_limit;
    logic inhibit_ff;

    always_comb begin
        case (cfg_ff[3:2])
            2'h0: tot_limit = `TKS_TOT_W'(TOT0_MS);
            2'h1: tot_limit = `TKS_TOT_W'(TOT1_MS);
            2'h2: tot_limit = `TKS_TOT_W'(TOT2_MS);
            default: tot_limit = `TKS_TOT_W'(TOT3_MS);
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !cmd_ff) begin
            tot_cnt_ff <= '0;
        end else if (tick && tot_cnt_ff != tot_limit) begin
            tot_cnt_ff <= tot_cnt_ff + `TKS_TOT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !cmd_ff) begin
            inhibit_ff <= 1'b0;
        end else if (tot_cnt_ff == tot_limit) begin
            inhibit_ff <= 1'b1;
        end
    end

    // ==========================================================
    // keying sequence
    // ==========================================================
    tks_pkg::tks_state_t state_ff, nxt_state;
    logic [`TKS_MS_W-1:0] ms_cnt_ff;
    logic talk;
    assign talk = cmd_ff && !inhibit_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            tks_pkg::ST_IDLE: begin
                if (talk) begin
                    nxt_state = tks_pkg::ST_KEYUP;
                end
            end
            tks_pkg::ST_KEYUP: begin
                if (inhibit_ff) begin
                    nxt_state = tks_pkg::ST_ANT;
                end else if (!cmd_ff) begin
                    nxt_state = tks_pkg::ST_HANG;
                end else if (ms_cnt_ff == `TKS_MS_W'(`TKS_CH1_DELAY_MS)) begin
                    nxt_state = tks_pkg::ST_KEYED;
                end
            end
            tks_pkg::ST_KEYED: begin
                if (inhibit_ff) begin
                    nxt_state = tks_pkg::ST_ANT;
                end else if (!cmd_ff) begin
                    nxt_state = tks_pkg::ST_HANG;
                end
            end
            tks_pkg::ST_HANG: begin
                if (talk) begin
                    nxt_state = channel_one_select ? tks_pkg::ST_KEYED : tks_pkg::ST_KEYUP;
                end else if (ms_cnt_ff == `TKS_MS_W'(`TKS_HANG_MS)) begin
                    nxt_state = tks_pkg::ST_ANT;
                end
            end
            tks_pkg::ST_ANT: begin
                if (talk) begin
                    nxt_state = tks_pkg::ST_KEYUP;
                end else if (ms_cnt_ff == `TKS_MS_W'(`TKS_ANT_DELAY_MS)) begin
                    nxt_state = tks_pkg::ST_IDLE;
                end
            end
            default: nxt_state = tks_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= tks_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || nxt_state != state_ff) begin
            ms_cnt_ff <= '0;
        end else if (tick) begin
            ms_cnt_ff <= ms_cnt_ff + `TKS_MS_W'(1);
        end
    end

    // ==========================================================
    // registered outputs
    // ==========================================================
    logic nxt_dly, nxt_ch1, nxt_gate;
    assign nxt_dly = nxt_state == tks_pkg::ST_KEYUP || nxt_state == tks_pkg::ST_KEYED
                     || nxt_state == tks_pkg::ST_HANG;
    assign nxt_ch1 = nxt_state == tks_pkg::ST_KEYED
                     || (nxt_state == tks_pkg::ST_HANG && channel_one_select);
    assign nxt_gate = cmd_ff && nxt_state != tks_pkg::ST_ANT && nxt_state != tks_pkg::ST_IDLE;

    // talk request follows command; rises at once
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            line_talk_request_n <= 1'b1;
            squelch_gate_block <= 1'b0;
            tone_squelch_bypass_clr <= 1'b0;
        end else begin
            line_talk_request_n <= !cmd_ff;
            squelch_gate_block <= cmd_ff && cfg_ff[1];
            tone_squelch_bypass_clr <= cmd_ff && cfg_ff[0];
        end
    end

    // keyed supply gate; normal tone phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            keyed_supply_gate <= 1'b0;
            tone_phase_normal <= 1'b0;
            encoder_turnoff <= 1'b0;
        end else begin
            keyed_supply_gate <= nxt_gate;
            tone_phase_normal <= nxt_gate;
            encoder_turnoff <= keyed_supply_gate && !nxt_gate;
        end
    end

    // exciter tracks delayed supply; hang regardless of squelch type
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            delayed_keyed_supply <= 1'b0;
            exciter_supply_en <= 1'b0;
            channel_one_select <= 1'b0;
            tx_keyed <= 1'b0;
        end else begin
            delayed_keyed_supply <= nxt_dly;
            exciter_supply_en <= nxt_dly;
            channel_one_select <= nxt_ch1;
            tx_keyed <= nxt_dly && nxt_ch1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ant_switch_mute_n <= 1'b1;
            ant_relay_en <= 1'b0;
            rx_audio_drv_en <= 1'b1;
            key_inhibit <= 1'b0;
        end else begin
            ant_switch_mute_n <= nxt_state == tks_pkg::ST_IDLE;
            ant_relay_en <= nxt_state != tks_pkg::ST_IDLE;
            rx_audio_drv_en <= nxt_state == tks_pkg::ST_IDLE;
            key_inhibit <= inhibit_ff;
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_TALK_FOLLOWS_CMD: assert property (cmd_ff |=> !line_talk_request_n)
        else $error("talk request not low after command");
    AST_CH1_AFTER_DELAY: assert property ($rose(channel_one_select) |->
        $past(state_ff) == tks_pkg::ST_KEYUP
        && $past(ms_cnt_ff) == `TKS_MS_W'(`TKS_CH1_DELAY_MS))
        else $error("channel select rose before keyup delay");
    AST_SUPPLY_WHILE_TALK: assert property (!line_talk_request_n && !key_inhibit
        && state_ff != tks_pkg::ST_ANT && state_ff != tks_pkg::ST_IDLE
        |-> keyed_supply_gate && exciter_supply_en && !ant_switch_mute_n)
        else $error("talk active without supply and antenna");
    AST_KEYED_NEEDS_CH1: assert property (tx_keyed |-> channel_one_select
        && exciter_supply_en)
        else $error("keyed without channel select");
    AST_RELAY_MUTE: assert property (ant_relay_en == !rx_audio_drv_en
        && ant_relay_en == !ant_switch_mute_n)
        else $error("relay and audio disagree");
    AST_HANG_LENGTH: assert property ($fell(delayed_keyed_supply) && !key_inhibit |->
        $past(ms_cnt_ff) == `TKS_MS_W'(`TKS_HANG_MS))
        else $error("supply dropped off hang time");
    AST_DROP_TOGETHER: assert property ($fell(delayed_keyed_supply) |->
        !exciter_supply_en && !channel_one_select)
        else $error("supply, select, exciter not dropped together");
    AST_ANT_DELAY: assert property ($rose(ant_switch_mute_n) |->
        $past(ms_cnt_ff) == `TKS_MS_W'(`TKS_ANT_DELAY_MS) && !exciter_supply_en)
        else $error("antenna released without turn-off delay");
    AST_INHIBIT_KILLS: assert property ($rose(inhibit_ff) |-> ##[1:2] !exciter_supply_en)
        else $error("inhibit did not drop exciter");
    AST_TURNOFF_PULSE: assert property ($fell(keyed_supply_gate) |-> encoder_turnoff
        ##1 !encoder_turnoff)
        else $error("no turn-off pulse on gate removal");
    AST_RESET_IDLE: assert property (@(posedge clk) $rose(rst_n) |-> line_talk_request_n
        && ant_switch_mute_n && !tx_keyed)
        else $error("outputs not idle after reset");

    COV_FULL_KEYUP: cover property ($rose(channel_one_select));
    COV_HANG_END: cover property (state_ff == tks_pkg::ST_HANG ##1 state_ff == tks_pkg::ST_ANT);
    COV_TOT_FIRE: cover property ($rose(key_inhibit));
    COV_REKEY_HANG: cover property (state_ff == tks_pkg::ST_HANG
        ##1 state_ff == tks_pkg::ST_KEYED);
endmodule : tks_sequencer
`default_nettype wire

// File: sim/tks_console_model.sv
`default_nettype none
// ======================================
// remote console, decoded dc line command
module tks_console_model (
    output var logic line_cmd_pos
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line_cmd_pos = 1'b0;
    task automatic set_cmd(input logic v);
        line_cmd_pos = v;
    endtask : set_cmd
endmodule : tks_console_model
`default_nettype wire

// File: sim/transmitter_keying_sequencer_tb.sv
`default_nettype none
module transmitter_keying_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // short tick makes each ms only 4 cycles long
    localparam int TK = 4;
    logic clk, rst_n, tone_dc, rptr;
    logic [1:0] tot_sel;
    wire logic cmd;
    logic talk_n, gate, dly, exc, ch1, txk, ant_n, relay, rxd, tph, eoff, sqb, bclr, inh;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;
    int t0, t1;

    tks_console_model u_con (.line_cmd_pos(cmd));
    // setting 0 keeps its long default: only settings 1..3 ever reach the limiter here
    tks_sequencer #(.TICK_CYCLES(TK), .TOT1_MS(110), .TOT2_MS(120),
        .TOT3_MS(130)) u_dut (.clk(clk), .rst_n(rst_n), .line_cmd_pos(cmd),
        .cfg_tone_and_dc(tone_dc), .cfg_repeater(rptr), .tot_sel(tot_sel),
        .line_talk_request_n(talk_n), .keyed_supply_gate(gate), .delayed_keyed_supply(dly),
        .exciter_supply_en(exc), .channel_one_select(ch1), .tx_keyed(txk),
        .ant_switch_mute_n(ant_n), .ant_relay_en(relay), .rx_audio_drv_en(rxd),
        .tone_phase_normal(tph), .encoder_turnoff(eoff), .squelch_gate_block(sqb),
        .tone_squelch_bypass_clr(bclr), .key_inhibit(inh));

    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    // ======================================
    // helpers
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check

    task automatic win(input string nm, input int d, input int lo, input int hi);
        check(nm, 32'(d >= lo && d <= hi), 32'h1);
    endtask : win

    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #2;
    endtask : step

    function automatic logic sel(input int k);
        case (k)
            0: sel = talk_n;
            1: sel = ch1;
            2: sel = exc;
            3: sel = ant_n;
            default: sel = inh;
        endcase
    endfunction : sel

    // bounded wait; running out ends the run as a failure
    task automatic wait_sig(input int k, input logic v, input int lim);
        int n;
        n = 0;
        while (sel(k) !== v && n < lim) begin
            step(1);
            n++;
        end
        if (n >= lim) begin
            check("wait bound", 32'h0, 32'h1);
            complete_run();
        end
    endtask : wait_sig

    // ======================================
    // scenarios
    task automatic do_reset(input int i);
        rst_n = 1'b0;
        rptr = i[0];
        tone_dc = i[1];
        tot_sel = i[1:0];
        u_con.set_cmd(1'b0);
        step(8);
        rst_n = 1'b1;
        step(1);
        check("idle outputs", {talk_n, ant_n, rxd, gate, dly, exc, ch1, txk, relay, tph, eoff,
            sqb, bclr, inh}, 32'h3800);
    endtask : do_reset

    task automatic key_up(input int i);
        u_con.set_cmd(1'b1);
        step(2);
        check("talk early", talk_n, 32'h1);
        step(1);
        t0 = cyc;
        check("key-up set", {talk_n, gate, dly, exc, ant_n, relay, rxd, tph, ch1, txk},
            32'h1D4);
        check("squelch block", sqb, 32'(i % 2));
        check("bypass clear", bclr, 32'(i / 2));
        wait_sig(1, 1'b1, 70 * TK);
        win("ch1 delay", cyc - t0, 60 * TK - 2, 61 * TK + 2);
        step(1);
        check("keyed", {txk, exc}, 32'h3);
    endtask : key_up

    // release, then key again well inside the hang: select was on, so no new 60 ms wait
    task automatic rekey();
        u_con.set_cmd(1'b0);
        step(3 + 20 * TK);
        check("hang held", {talk_n, tph, dly, ch1, txk}, 32'h17);
        u_con.set_cmd(1'b1);
        step(3);
        check("rekey in hang", {talk_n, gate, ch1, txk, exc}, 32'hF);
    endtask : rekey

    task automatic key_down();
        u_con.set_cmd(1'b0);
        step(3);
        t1 = cyc;
        check("release", {talk_n, gate, tph, eoff, dly, exc, ch1}, 32'h4F);
        step(1);
        check("turnoff pulse", eoff, 32'h0);
        wait_sig(2, 1'b0, 200 * TK);
        win("hang time", cyc - t1, 180 * TK - 2, 181 * TK + 2);
        check("drop together", {dly, ch1, ant_n}, 32'h0);
        t1 = cyc;
        step(1);
        check("unkeyed", txk, 32'h0);
        wait_sig(3, 1'b1, 40 * TK);
        win("antenna delay", cyc - t1, 30 * TK - 2, 31 * TK + 2);
        check("standby", {relay, rxd}, 32'h1);
    endtask : key_down

    task automatic limiter(input int i);
        wait_sig(4, 1'b1, 200 * TK);
        win("limiter period", cyc - t0, (100 + 10 * i) * TK - 2, (101 + 10 * i) * TK + 3);
        step(2);
        check("inhibit off", {exc, ch1, txk, talk_n, ant_n}, 32'h0);
        t1 = cyc;
        wait_sig(3, 1'b1, 40 * TK);
        win("inhibit antenna", cyc - t1, 29 * TK - 2, 32 * TK + 3);
        check("held command", {talk_n, inh, exc}, 32'h2);
        u_con.set_cmd(1'b0);
        step(5);
        check("inhibit clear", {inh, exc, talk_n}, 32'h1);
    endtask : limiter

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        tone_dc = 1'b0;
        rptr = 1'b0;
        tot_sel = 2'h0;
        for (int i = 0; i < 4; i++) begin
            do_reset(i);
            key_up(i);
            if (i == 0) begin
                rekey();
                key_down();
            end else begin
                limiter(i);
            end
        end
        complete_run();
    end
endmodule : transmitter_keying_sequencer_tb
`default_nettype wire
